/* File: bench/rwm_chk_sva.sv */
// Purpose: port assertions for the width control block
// Assumes: master holds address and direction through the ack cycle
// Notes:   one clock domain, so default clocking and disable apply
`timescale 1ns/100ps
`include "rwm_map.svh"
module rwm_chk (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               cyc_i,
  input wire logic               stb_i,
  input wire logic               we_i,
  input wire logic [3:0]         sel_i,
  input wire logic [7:0]         adr_i,
  input wire logic [31:0]        dat_i,
  input wire logic [31:0]        dat_o,
  input wire logic               ack_o,
  input wire rwm_pkg::rwm_mode_t mode_o,
  input wire logic               mem_wide_o,
  input wire logic               idx_wide_o,
  input wire logic               cpu_clk_o
);
  import rwm_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rd;
  assign rd = ack_o && !we_i;
  ////////////////////////////////////////////////////////////////////////
  a_acc_narrow: assert property (mode_o.acc8 |-> !mem_wide_o)
    else $error("memory width wide while flag set");
  a_acc_wide: assert property (!mode_o.acc8 |-> mem_wide_o)
    else $error("memory width narrow while flag clear");
  a_emu_acc: assert property (mode_o.emu |-> mode_o.acc8)
    else $error("acc flag clear in emulation");
  a_idx_narrow: assert property (mode_o.idx8 |-> !idx_wide_o)
    else $error("index width wide while flag set");
  a_idx_wide: assert property (!mode_o.idx8 |-> idx_wide_o)
    else $error("index width narrow while flag clear");
  a_clk_half: assert property ($changed(cpu_clk_o) |=>
    $stable(cpu_clk_o)[*7]) else $error("cpu clock half period short");
  a_idx_upper: assert property (rd && mode_o.idx8 &&
    adr_i inside {`RWM_ADR_IDX_X, `RWM_ADR_IDX_Y} |-> dat_o[15:8] == 8'h00)
    else $error("index upper byte not zero");
  a_acc_upper: assert property (rd && mode_o.emu &&
    adr_i == `RWM_ADR_ACC |-> dat_o[15:8] == 8'h00)
    else $error("acc upper byte not zero");
  a_emu_idx: assert property (mode_o.emu |-> mode_o.idx8)
    else $error("index flag clear in emulation");
  a_ack_once: assert property ($rose(cyc_i && stb_i) |=> ack_o ##1 !ack_o)
    else $error("ack not a single cycle after request");
  c_native: cover property (mode_o == 3'b000);
  c_acc_rd: cover property (rd && adr_i == `RWM_ADR_ACC);
  c_clk: cover property ($rose(cpu_clk_o));
endmodule

/* File: bench/rwm_cpu_side.sv */
// Purpose: processor side of the clock, measures each clock level
// Assumes: cpu clock sampled on the core clock
// Notes:   half_o is the length of the last finished level in cycles
`timescale 1ns/100ps
module rwm_cpu_side (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       cpu_clk_i,
  output logic      [7:0] half_o
);
  logic       last_q;
  logic [7:0] cnt_q;
  always_ff @(posedge clk_i) begin
    last_q <= cpu_clk_i;
    if (rst_i) begin
      cnt_q  <= 8'h00;
      half_o <= 8'h00;
    end else if (last_q != cpu_clk_i) begin
      half_o <= cnt_q;
      cnt_q  <= 8'h01;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule

/* File: bench/testbench.sv */
// Purpose: register level tests of the width control block
// Assumes: one wishbone cycle at a time, a free cycle between them
// Notes:   expected values come from the width rules, not the design
`timescale 1ns/100ps
`include "rwm_map.svh"
module testbench;
  import rwm_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, half;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic ack_o, mem_wide_o, idx_wide_o, cpu_clk_o;
  rwm_mode_t mode_o;
  int failures = 0, comparisons = 0, cycles = 0;
  always #12.5 clk_i = ~clk_i;
  rwm_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .sel_i(sel), .adr_i(adr), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .mode_o(mode_o), .mem_wide_o(mem_wide_o),
    .idx_wide_o(idx_wide_o), .cpu_clk_o(cpu_clk_o));
  rwm_cpu_side cpu (.clk_i(clk_i), .rst_i(rst_i), .cpu_clk_i(cpu_clk_o),
    .half_o(half));
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // holds the request until ack is sampled, then a free cycle
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'h3;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    q = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) if (++cycles > 3000) begin
    failures++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("mode", 3'h7, mode_o);
    xfer(1, `RWM_ADR_STATUS, 32'h4);
    chk("mode", 3'h7, mode_o);
    xfer(0, `RWM_ADR_STATUS, 0);
    chk("status", 32'h7, q);
    xfer(1, `RWM_ADR_ACC, 32'h1234);
    xfer(0, `RWM_ADR_ACC, 0);
    chk("acc", 32'h34, q);
    xfer(1, `RWM_ADR_IDX_X, 32'habcd);
    xfer(0, `RWM_ADR_IDX_X, 0);
    chk("x", 32'hcd, q);
    $display("test emulation done");
    xfer(1, `RWM_ADR_STATUS, 32'h3);
    chk("widths", 2'b00, {mem_wide_o, idx_wide_o});
    xfer(1, `RWM_ADR_STATUS, 32'h0);
    chk("widths", 2'b11, {mem_wide_o, idx_wide_o});
    xfer(0, `RWM_ADR_WIDTH, 0);
    chk("width reg", 32'h3, q);
    xfer(1, `RWM_ADR_ACC, 32'hbeef);
    xfer(0, `RWM_ADR_ACC, 0);
    chk("acc", 32'hbeef, q);
    xfer(1, `RWM_ADR_IDX_Y, 32'h5a5a);
    xfer(0, `RWM_ADR_IDX_Y, 0);
    chk("y", 32'h5a5a, q);
    xfer(1, `RWM_ADR_STATUS, 32'h1);
    xfer(0, `RWM_ADR_IDX_Y, 0);
    chk("y", 32'h5a, q);
    xfer(1, `RWM_ADR_IDX_Y, 32'h1111);
    xfer(0, `RWM_ADR_IDX_Y, 0);
    chk("y", 32'h11, q);
    xfer(1, `RWM_ADR_STATUS, 32'h2);
    xfer(1, `RWM_ADR_ACC, 32'h1234);
    xfer(0, `RWM_ADR_ACC, 0);
    chk("acc", 32'hbe34, q);
    xfer(1, `RWM_ADR_STATUS, 32'h4);
    chk("mode", 3'h7, mode_o);
    xfer(0, `RWM_ADR_ACC, 0);
    chk("acc", 32'h34, q);
    xfer(0, 8'h20, 0);
    chk("unmapped", 32'h0, q);
    $display("test widths done");
    repeat (100) @(posedge clk_i);
    chk("slow half", 8'd20, half);
    xfer(1, `RWM_ADR_CONFIG, 32'h1);
    xfer(0, `RWM_ADR_CONFIG, 0);
    chk("config", 32'h1, q);
    repeat (60) @(posedge clk_i);
    chk("fast half", 8'd8, half);
    $display("test clock done");
    summarize();
  end
endmodule
bind rwm_top rwm_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .mode_o(mode_o), .mem_wide_o(mem_wide_o),
  .idx_wide_o(idx_wide_o), .cpu_clk_o(cpu_clk_o));

/* File: hw/rwm_clkgen.sv */
// Purpose: processor clock divider for the two speeds
// Assumes: fast_i comes from a register on clk_i
// Notes:   speed changes take effect at once, shortening or stretching the half period in progress
`timescale 1ns/100ps
`include "rwm_map.svh"
module rwm_clkgen #(
  parameter int unsigned CLK_KHZ  = `RWM_CLK_KHZ,
  parameter int unsigned SLOW_KHZ = `RWM_SLOW_KHZ,
  parameter int unsigned FAST_KHZ = `RWM_FAST_KHZ
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic fast_i,
  output logic      cpu_clk_o
);
  import rwm_pkg::*;

  // half periods in core cycles, rounded down, never under one
  localparam int unsigned HALF_SLOW_RAW = CLK_KHZ / (2 * SLOW_KHZ);
  localparam int unsigned HALF_FAST_RAW = CLK_KHZ / (2 * FAST_KHZ);
  localparam int unsigned HALF_SLOW =
    (HALF_SLOW_RAW < 1) ? 1 : HALF_SLOW_RAW;
  localparam int unsigned HALF_FAST =
    (HALF_FAST_RAW < 1) ? 1 : HALF_FAST_RAW;
  localparam logic [7:0] SLOW_LAST = 8'(HALF_SLOW - 1);
  localparam logic [7:0] FAST_LAST = 8'(HALF_FAST - 1);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       clk_q;
  logic       clk_d;
  logic [7:0] last;

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    last  = fast_i ? FAST_LAST : SLOW_LAST;
    cnt_d = cnt_q + 8'h01;
    clk_d = clk_q;
    if (cnt_q >= last) begin
      cnt_d = 8'h00;
      clk_d = ~clk_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 8'h00;
      clk_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

  assign cpu_clk_o = clk_q;
endmodule

/* File: hw/rwm_map.svh */
// Purpose: register offsets, field positions, reset values and timing
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   shared by the top and clock divider design files of the width control block
`ifndef RWM_MAP_SVH
`define RWM_MAP_SVH

`define RWM_ADR_STATUS  8'h00
`define RWM_ADR_ACC     8'h04
`define RWM_ADR_IDX_X   8'h08
`define RWM_ADR_IDX_Y   8'h0c
`define RWM_ADR_CONFIG  8'h10
`define RWM_ADR_WIDTH   8'h14

`define RWM_BIT_X       0
`define RWM_BIT_M       1
`define RWM_BIT_E       2
`define RWM_BIT_SPEED   0

`define RWM_STATUS_RST  3'h7
`define RWM_CONFIG_RST  1'h0

// core clock in kHz, slow and fast cpu clock in kHz
`define RWM_CLK_KHZ     40000
`define RWM_SLOW_KHZ    1000
`define RWM_FAST_KHZ    2500

`endif

/* File: hw/rwm_pkg.sv */
// Purpose: types for the width control block
// Assumes: constants come from rwm_map.svh
// Notes:   packed structs carry the mode flags and bus request
package rwm_pkg;

  typedef struct packed {
    logic emu;
    logic acc8;
    logic idx8;
  } rwm_mode_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } rwm_wb_req_t;

  typedef enum logic [1:0] {
    RWM_BUS_IDLE = 2'b00,
    RWM_BUS_ACK  = 2'b01
  } rwm_bus_state_t;

endpackage

/* File: hw/rwm_top.sv */
// Purpose: operand width control, width-masked registers, clock select
// Assumes: classic wishbone master, one outstanding cycle
// Notes:   software plays the processor core through the registers
`timescale 1ns/100ps
`include "rwm_map.svh"
module rwm_top (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         cyc_i,
  input  wire logic         stb_i,
  input  wire logic         we_i,
  input  wire logic [3:0]   sel_i,
  input  wire logic [7:0]   adr_i,
  input  wire logic [31:0]  dat_i,
  output logic      [31:0]  dat_o,
  output logic              ack_o,
  output rwm_pkg::rwm_mode_t mode_o,
  output logic              mem_wide_o,
  output logic              idx_wide_o,
  output logic              cpu_clk_o
);
  import rwm_pkg::*;

  rwm_wb_req_t    req;
  rwm_bus_state_t st_q;
  rwm_bus_state_t st_d;
  rwm_mode_t      mode_q;
  rwm_mode_t      mode_d;
  logic [15:0]    acc_q;
  logic [15:0]    acc_d;
  logic [15:0]    idx_x_q;
  logic [15:0]    idx_x_d;
  logic [15:0]    idx_y_q;
  logic [15:0]    idx_y_d;
  logic           fast_q;
  logic           fast_d;
  logic [31:0]    rdat_q;
  logic [31:0]    rdat_d;
  logic           wr_go;
  logic           rd_go;

  // merge a write into a 16-bit word; upper lanes blocked when narrow
  function automatic logic [15:0] wr16(input logic [15:0] old,
                                       input logic [31:0] wd,
                                       input logic [3:0]  sel,
                                       input logic        narrow);
    logic [15:0] r;
    r = old;
    if (sel[0])
      r[7:0] = wd[7:0];
    if (sel[1] && !narrow)
      r[15:8] = wd[15:8];
    return r;
  endfunction

  // width-masked view of a 16-bit register
  function automatic logic [15:0] view16(input logic [15:0] v,
                                         input logic        narrow);
    return narrow ? {8'h00, v[7:0]} : v;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // bus slave: ack one cycle after the request, dropped the next cycle
  assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                 adr: adr_i, dat: dat_i};

  always_comb begin
    st_d = st_q;
    case (st_q)
      RWM_BUS_IDLE: begin
        if (req.cyc && req.stb)
          st_d = RWM_BUS_ACK;
      end
      RWM_BUS_ACK: begin
        st_d = RWM_BUS_IDLE;
      end
      default: begin
        st_d = RWM_BUS_IDLE;
      end
    endcase
  end

  assign ack_o = (st_q == RWM_BUS_ACK);
  // write commits at the acknowledging edge, as the master samples it
  assign wr_go = ack_o && req.cyc && req.stb && req.we;
  assign rd_go = (st_q == RWM_BUS_IDLE) && req.cyc && req.stb && !req.we;

  //////////////////////////////////////////////////////////////////////
  // mode flags and width-masked registers
  always_comb begin
    mode_d  = mode_q;
    acc_d   = acc_q;
    idx_x_d = idx_x_q;
    idx_y_d = idx_y_q;
    fast_d  = fast_q;
    if (wr_go) begin
      case (req.adr)
        `RWM_ADR_STATUS: begin
          if (req.sel[0]) begin
            mode_d.emu  = req.dat[`RWM_BIT_E];
            mode_d.acc8 = req.dat[`RWM_BIT_M];
            mode_d.idx8 = req.dat[`RWM_BIT_X];
          end
        end
        `RWM_ADR_ACC: begin
          acc_d = wr16(acc_q, req.dat, req.sel, mode_q.acc8);
        end
        `RWM_ADR_IDX_X: begin
          idx_x_d = wr16(idx_x_q, req.dat, req.sel, mode_q.idx8);
        end
        `RWM_ADR_IDX_Y: begin
          idx_y_d = wr16(idx_y_q, req.dat, req.sel, mode_q.idx8);
        end
        `RWM_ADR_CONFIG: begin
          if (req.sel[0])
            fast_d = req.dat[`RWM_BIT_SPEED];
        end
        default: begin
        end
      endcase
    end
    if (mode_d.emu) begin
      mode_d.acc8 = 1'b1;
      mode_d.idx8 = 1'b1;
    end
    // emulation clears the acc upper byte, idx8 clears the x and y upper bytes, so they stay zero when read
    if (mode_d.emu)
      acc_d[15:8] = 8'h00;
    if (mode_d.idx8) begin
      idx_x_d[15:8] = 8'h00;
      idx_y_d[15:8] = 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read mux; upper half of acc hidden only in emulation, as held
  always_comb begin
    rdat_d = rdat_q;
    if (rd_go) begin
      case (req.adr)
        `RWM_ADR_STATUS:
          rdat_d = {29'h0, mode_q.emu, mode_q.acc8, mode_q.idx8};
        `RWM_ADR_ACC:
          rdat_d = {16'h0, view16(acc_q, mode_q.emu)};
        `RWM_ADR_IDX_X:
          rdat_d = {16'h0, view16(idx_x_q, mode_q.idx8)};
        `RWM_ADR_IDX_Y:
          rdat_d = {16'h0, view16(idx_y_q, mode_q.idx8)};
        `RWM_ADR_CONFIG:
          rdat_d = {31'h0, fast_q};
        `RWM_ADR_WIDTH:
          rdat_d = {30'h0, mem_wide_o, idx_wide_o};
        default:
          rdat_d = 32'h0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // registers, one process per group
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= RWM_BUS_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q  <= rwm_mode_t'(`RWM_STATUS_RST);
      acc_q   <= 16'h0000;
      idx_x_q <= 16'h0000;
      idx_y_q <= 16'h0000;
      fast_q  <= `RWM_CONFIG_RST;
    end else begin
      mode_q  <= mode_d;
      acc_q   <= acc_d;
      idx_x_q <= idx_x_d;
      idx_y_q <= idx_y_d;
      fast_q  <= fast_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      rdat_q <= rdat_d;
    end
  end

  assign dat_o      = rdat_q;
  assign mode_o     = mode_q;
  assign mem_wide_o = !mode_q.acc8;
  assign idx_wide_o = !mode_q.idx8;

  //////////////////////////////////////////////////////////////////////
  rwm_clkgen u_clkgen (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .fast_i    (fast_q),
    .cpu_clk_o (cpu_clk_o)
  );
endmodule
